// ### rtl/bie_core.sv
// Execution core for the absolute branch and increment instructions.
// How it works
// - Branch is two words: fixed byte with k7..0, then 1111 with k19..8.
// - Branch loads the 20-bit target into counter bits 20..1, bit 0 clear.
// - Target spans 0 to 1048575, the whole 2-Mbyte program space.
// - Branch takes two cycles; the second is idle in every phase.
// - Q1 decode, Q2 take k7..0, Q3 idle, Q4 take k19..8, write counter.
// - Increments add one; destination 0 writes working register, 1 the file.
// - Plain increment opcode is 0010 10da then the eight-bit address.
// - Plain increment updates carry, digit carry, negative, overflow, zero.
// - Plain increment: one cycle; decode, read, process, write destination.
// - Skip-on-zero opcode is 0011 11da plus address; flags untouched.
// - A zero result discards the fetched next word and runs idle instead.
// - Skip costs one idle cycle, two if the skipped word is two-word.
// - Access 0 picks the shared bank; 1 uses the bank select value.
// - Access 0, extended set, address up to 95: indexed literal offset.
// - Decrement opcode 0100 11da subtracts one, skips on nonzero result.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "bie_params.svh"

module bie_core #(
  parameter int DAW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Program memory fetch
  output logic [20:0] pmem_addr,
  input wire logic [15:0] pmem_data
);

  bie_pkg::bie_phase_t phase;
  bie_pkg::bie_dec_t dec_now;
  bie_pkg::bie_dec_t dec;
  logic [15:0] ir;
  logic [1:0] flush_cnt;
  logic exec;
  logic [1:0] ctrl;
  logic [7:0] bank;
  logic [7:0] wreg;
  logic [4:0] status;
  logic [20:0] pc;
  logic [DAW-1:0] index_base;
  logic [DAW-1:0] maddr;
  logic [DAW-1:0] eaddr;
  logic [7:0] lit_low;
  logic [7:0] rdata;
  logic [7:0] result;
  logic [7:0] operand;
  logic [7:0] mdata;
  logic bus_req;
  logic bus_wr;
  logic file_we;
  logic result_zero;
  logic skip;
  logic arith;
  logic bus_pc_wr;

  // A word belongs to a two-word instruction when its top bits say so.
  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[15:12] == 4'hc) || (w[15:9] == 7'h76) ||
               (w[15:8] == 8'hee) || (w[15:8] == `BIE_OPC_BRANCH);
  endfunction

  // Effective data address of a file operand.
  function automatic logic [DAW-1:0] file_addr(input logic access,
      input logic [7:0] f, input logic [7:0] bsel, input logic ext,
      input logic [DAW-1:0] base);
    logic [DAW-1:0] a;
    a = '0;
    if (access) begin
      a = DAW'({bsel[3:0], f});
    end else if (ext && f <= `BIE_ILO_LIMIT) begin
      a = base + DAW'(f);
    end else if (f < `BIE_ACCESS_SPLIT) begin
      a = DAW'(f);
    end else begin
      a = DAW'({`BIE_ACCESS_HIGH_BANK, f});
    end
    file_addr = a;
  endfunction

  bie_decode u_decode (
    .ir(ir),
    .dec(dec_now)
  );

  bie_regfile #(
    .AW(DAW)
  ) u_regfile (
    .clk(clk),
    .a_addr(eaddr),
    .a_we(file_we),
    .a_wdata(result),
    .a_rdata(rdata),
    .b_addr(maddr),
    .b_we(bus_wr && wb_adr_i == `BIE_REG_MDATA),
    .b_wdata(wb_dat_i[7:0]),
    .b_rdata(mdata)
  );

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign pmem_addr = pc;
  assign arith = exec && (dec.op == bie_pkg::BIE_OP_INC ||
                          dec.op == bie_pkg::BIE_OP_INCSZ ||
                          dec.op == bie_pkg::BIE_OP_DECSNZ);
  assign result_zero = (result == 8'h00);
  // A counter load from the bus lands whenever the core is not running at its Q4.
  assign bus_pc_wr = bus_wr && wb_adr_i == `BIE_REG_PC &&
                     !(ctrl[`BIE_CTRL_RUN] && phase == bie_pkg::BIE_PH_Q4);
  // destination one goes to the file
  // A halted core frozen at Q4 must not keep rewriting the file.
  assign file_we = ctrl[`BIE_CTRL_RUN] && phase == bie_pkg::BIE_PH_Q4 &&
                   arith && dec.dest;
  assign skip = (dec.op == bie_pkg::BIE_OP_INCSZ && result_zero) ||
                (dec.op == bie_pkg::BIE_OP_DECSNZ && !result_zero);

  // Four phases per instruction cycle; halted cores hold their phase.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= bie_pkg::BIE_PH_Q1;
    end else if (bus_pc_wr) begin
      // A new counter restarts the cycle so no half-done one resumes.
      phase <= bie_pkg::BIE_PH_Q1;
    end else if (ctrl[`BIE_CTRL_RUN]) begin
      case (phase)
        bie_pkg::BIE_PH_Q1: phase <= bie_pkg::BIE_PH_Q2;
        bie_pkg::BIE_PH_Q2: phase <= bie_pkg::BIE_PH_Q3;
        bie_pkg::BIE_PH_Q3: phase <= bie_pkg::BIE_PH_Q4;
        default: phase <= bie_pkg::BIE_PH_Q1;
      endcase
    end
  end

  // Q1 decodes; a pending flush turns the cycle into an idle one.
  // Q1 decode step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec <= '0;
      exec <= 1'b0;
      eaddr <= '0;
    end else if (bus_pc_wr) begin
      exec <= 1'b0;
    end else if (ctrl[`BIE_CTRL_RUN] && phase == bie_pkg::BIE_PH_Q1) begin
      dec <= dec_now;
      exec <= (flush_cnt == 2'h0);
      eaddr <= file_addr(dec_now.access, dec_now.f, bank,
                         ctrl[`BIE_CTRL_EXT], index_base);
    end
  end

  // Q2 reads the file (in the memory) and the low literal; Q3 processes.
  // low literal in Q2
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lit_low <= 8'h00;
      operand <= 8'h00;
      result <= 8'h00;
    end else if (ctrl[`BIE_CTRL_RUN]) begin
      if (phase == bie_pkg::BIE_PH_Q2) begin
        lit_low <= ir[7:0];
      end
      if (phase == bie_pkg::BIE_PH_Q3) begin
        operand <= rdata;
        result <= (dec.op == bie_pkg::BIE_OP_DECSNZ) ? rdata - 8'h01 :
                  rdata + 8'h01;
      end
    end
  end

  // Flags change only for the plain increment, at Q4, and on a bus write to the status register.
  // increment flag update
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status <= 5'h00;
    end else if (ctrl[`BIE_CTRL_RUN] && phase == bie_pkg::BIE_PH_Q4 &&
                 exec && dec.op == bie_pkg::BIE_OP_INC) begin
      status[`BIE_ST_C] <= (operand == 8'hff);
      status[`BIE_ST_DC] <= (operand[3:0] == 4'hf);
      status[`BIE_ST_Z] <= result_zero;
      status[`BIE_ST_OV] <= (operand == 8'h7f);
      status[`BIE_ST_N] <= result[7];
    end else if (bus_wr && wb_adr_i == `BIE_REG_STATUS) begin
      status <= wb_dat_i[4:0];
    end
  end

  // Working register: the core's Q4 write takes precedence over the bus.
  // destination zero to working register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wreg <= 8'h00;
    end else if (ctrl[`BIE_CTRL_RUN] && phase == bie_pkg::BIE_PH_Q4 &&
                 arith && !dec.dest) begin
      wreg <= result;
    end else if (bus_wr && wb_adr_i == `BIE_REG_WREG) begin
      wreg <= wb_dat_i[7:0];
    end
  end

  // Q4 fetches the next word, steps or loads the counter, and sets flushes.
  // A bus write to the counter outside a running Q4 forces one idle cycle so the pipe refills.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc <= `BIE_PC_RESET;
      ir <= 16'h0000;
      flush_cnt <= `BIE_FLUSH_RESET;
    end else if (ctrl[`BIE_CTRL_RUN] && phase == bie_pkg::BIE_PH_Q4) begin
      ir <= pmem_data;
      if (exec && dec.op == bie_pkg::BIE_OP_BRANCH) begin
        pc <= {pmem_data[11:0], lit_low, 1'b0};
        flush_cnt <= 2'h1;
      end else begin
        pc <= pc + 21'h000002;
        if (exec && skip) begin
          flush_cnt <= two_word(pmem_data) ? 2'h2 : 2'h1;
        end else if (!exec) begin
          flush_cnt <= flush_cnt - 2'h1;
        end
      end
    end else if (bus_wr && wb_adr_i == `BIE_REG_PC) begin
      pc <= {wb_dat_i[20:1], 1'b0};
      flush_cnt <= 2'h1;
    end
  end

  // Software registers other than flags, working register and counter.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= `BIE_CTRL_RESET;
      bank <= 8'h00;
      index_base <= '0;
      maddr <= '0;
    end else if (bus_wr) begin
      case (wb_adr_i)
        `BIE_REG_CTRL: ctrl <= wb_dat_i[1:0];
        `BIE_REG_BANK: bank <= wb_dat_i[7:0];
        `BIE_REG_INDEX: index_base <= wb_dat_i[DAW-1:0];
        `BIE_REG_MADDR: maddr <= wb_dat_i[DAW-1:0];
        default: ;
      endcase
    end
  end

  // Every request is answered one cycle after it is seen; unmapped reads 0.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `BIE_REG_CTRL: wb_dat_o <= {30'h00000000, ctrl};
          `BIE_REG_BANK: wb_dat_o <= {24'h000000, bank};
          `BIE_REG_WREG: wb_dat_o <= {24'h000000, wreg};
          `BIE_REG_STATUS: wb_dat_o <= {27'h0000000, status};
          `BIE_REG_PC: wb_dat_o <= {11'h000, pc};
          `BIE_REG_INDEX: wb_dat_o <= 32'(index_base);
          `BIE_REG_MADDR: wb_dat_o <= 32'(maddr);
          `BIE_REG_MDATA: wb_dat_o <= {24'h000000, mdata};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ### rtl/bie_decode.sv
// Opcode decoder for the branch and increment instructions.
`timescale 1ns/1ps
`include "bie_params.svh"

module bie_decode (
  // Instruction word
  input wire logic [15:0] ir,
  // Decoded fields
  output bie_pkg::bie_dec_t dec
);

  // Split the word into operation and operand fields.
  always_comb begin
    dec.dest = ir[9];
    dec.access = ir[8];
    dec.f = ir[7:0];
    if (ir[15:8] == `BIE_OPC_BRANCH) begin
      dec.op = bie_pkg::BIE_OP_BRANCH;
    end else if (ir[15:10] == `BIE_OPC_INC) begin
      dec.op = bie_pkg::BIE_OP_INC;
    end else if (ir[15:10] == `BIE_OPC_INCSZ) begin
      dec.op = bie_pkg::BIE_OP_INCSZ;
    end else if (ir[15:10] == `BIE_OPC_DECSNZ) begin
      dec.op = bie_pkg::BIE_OP_DECSNZ;
    end else begin
      dec.op = bie_pkg::BIE_OP_IDLE; // Anything else runs as idle.
    end
  end

endmodule

// ### rtl/bie_params.svh
// Constants for the branch and increment execution block.
`ifndef BIE_PARAMS_SVH
`define BIE_PARAMS_SVH

// Register byte offsets on the Wishbone slave.
`define BIE_REG_CTRL 8'h00
`define BIE_REG_BANK 8'h04
`define BIE_REG_WREG 8'h08
`define BIE_REG_STATUS 8'h0c
`define BIE_REG_PC 8'h10
`define BIE_REG_INDEX 8'h14
`define BIE_REG_MADDR 8'h18
`define BIE_REG_MDATA 8'h1c

// Control register fields.
`define BIE_CTRL_RUN 0
`define BIE_CTRL_EXT 1
`define BIE_CTRL_RESET 2'h0

// Status register fields.
`define BIE_ST_C 0
`define BIE_ST_DC 1
`define BIE_ST_Z 2
`define BIE_ST_OV 3
`define BIE_ST_N 4

// Opcode patterns.
`define BIE_OPC_BRANCH 8'hef
`define BIE_OPC_BRANCH2 4'hf
`define BIE_OPC_INC 6'h0a
`define BIE_OPC_INCSZ 6'h0f
`define BIE_OPC_DECSNZ 6'h13

// Data addressing.
`define BIE_ILO_LIMIT 8'h5f
`define BIE_ACCESS_SPLIT 8'h60
`define BIE_ACCESS_HIGH_BANK 4'hf

// Reset values.
`define BIE_PC_RESET 21'h000000
`define BIE_FLUSH_RESET 2'h1

`endif

// ### rtl/bie_pkg.sv
// Types shared by the branch and increment execution block.
package bie_pkg;

  typedef enum logic [2:0] {
    BIE_OP_IDLE,
    BIE_OP_BRANCH,
    BIE_OP_INC,
    BIE_OP_INCSZ,
    BIE_OP_DECSNZ
  } bie_op_t;

  typedef enum logic [1:0] {
    BIE_PH_Q1,
    BIE_PH_Q2,
    BIE_PH_Q3,
    BIE_PH_Q4
  } bie_phase_t;

  typedef struct packed {
    bie_op_t op;
    logic dest;
    logic access;
    logic [7:0] f;
  } bie_dec_t;

endpackage

// ### rtl/bie_regfile.sv
// Dual-port data register file with registered read data.
`timescale 1ns/1ps

module bie_regfile #(
  parameter int AW = 12
) (
  // Clock
  input wire logic clk,
  // Core port
  input wire logic [AW-1:0] a_addr,
  input wire logic a_we,
  input wire logic [7:0] a_wdata,
  output logic [7:0] a_rdata,
  // Bus port
  input wire logic [AW-1:0] b_addr,
  input wire logic b_we,
  input wire logic [7:0] b_wdata,
  output logic [7:0] b_rdata
);

  logic [7:0] mem [0:(1<<AW)-1];

  // Both ports write; the core port is applied last so it wins a tie.
  always_ff @(posedge clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  // Read data leave through registers.
  always_ff @(posedge clk) begin
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule

// ### tb/bie_core_assertions.sv
// Concurrent checks on the execution core's ports.
`timescale 1ns/1ps
`include "bie_params.svh"
module bie_core_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Program memory fetch
  input wire logic [20:0] pmem_addr,
  input wire logic [15:0] pmem_data
);
  logic req;
  logic rdq;
  logic [15:0] prev_word;
  logic [20:0] prev_addr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // A request is taken on an edge where it is up and ack is low.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rdq = req && !wb_we_i;

  // Last fetched word and address, one clock behind.
  always_ff @(posedge clk) begin
    prev_word <= pmem_data;
    prev_addr <= pmem_addr;
  end

  property p_ack_next;
    req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_no_stray_ack;
    !req |=> !wb_ack_o;
  endproperty
  a_no_stray_ack: assert property (p_no_stray_ack)
    else $error("ack without request");
  property p_unmapped;
    rdq && wb_adr_i > 8'h1c |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_pc_read;
    rdq && wb_adr_i == `BIE_REG_PC |=> wb_dat_o == {11'h0, prev_addr};
  endproperty
  a_pc_read: assert property (p_pc_read)
    else $error("counter read differs from fetch address");
  property p_status_width;
    rdq && wb_adr_i == `BIE_REG_STATUS |=> wb_dat_o[31:5] == 27'h0;
  endproperty
  a_status_width: assert property (p_status_width)
    else $error("status has bits above the five flags");
  property p_pc_even;
    pmem_addr[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even)
    else $error("fetch address odd");
  // Every fetch address holds for a whole four-phase cycle.
  property p_fetch_hold;
    $changed(pmem_addr) |=> $stable(pmem_addr) [*3];
  endproperty
  a_fetch_hold: assert property (p_fetch_hold)
    else $error("fetch address held under four clocks");
  // A branch word loads its target, or if skipped only advances the counter past both words.
  property p_branch;
    logic [7:0] lo;
    logic [20:0] a;
    ($changed(pmem_addr) && prev_word[15:8] == 8'hef,
      lo = prev_word[7:0], a = prev_addr) ##1 !wb_cyc_i [*4] |->
      pmem_addr == {prev_word[11:0], lo, 1'b0} || pmem_addr == a + 21'h4;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target not loaded");
endmodule

bind bie_core bie_core_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pmem_addr(pmem_addr),
  .pmem_data(pmem_data));

// ### tb/bie_pmem.sv
// Program memory model that answers the fetch address at once.
`timescale 1ns/1ps
module bie_pmem (
  // Fetch port
  input wire logic [20:0] pmem_addr,
  output logic [15:0] pmem_data
);
  logic [15:0] mem [0:255];
  // High address bits alias, so far targets land in the small array.
  assign pmem_data = mem[pmem_addr[8:1]];
endmodule

// ### tb/branch_and_increment_exec_tb.sv
// Self-checking bench for the branch and increment execution core.
`timescale 1ns/1ps
`include "bie_params.svh"
module branch_and_increment_exec_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [20:0] pmem_addr;
  logic [15:0] pmem_data;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  // Five programs, each ending in a branch to itself.
  logic [15:0] prog [0:33] = '{16'h2b34, 16'hef01, 16'hf000, 16'h0,
    16'h2935, 16'hef05, 16'hf000, 16'h0, 16'h2a05, 16'h3f38, 16'h3f36,
    16'h2b37, 16'hef0c, 16'hf000, 16'h0, 16'h0, 16'h4f3a, 16'h2b3b,
    16'h3f3c, 16'hef40, 16'hf000, 16'h2b3d, 16'hef16, 16'hf000, 16'h2a10,
    16'h2a5f, 16'h2a60, 16'hef20, 16'hf800, 16'h2b3e, 16'h0, 16'h0,
    16'hef20, 16'hf800};

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  bie_core u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pmem_addr(pmem_addr), .pmem_data(pmem_data));
  bie_pmem u_mem (.pmem_addr(pmem_addr), .pmem_data(pmem_data));

  task automatic tally_and_finish();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the request holds until ack is seen at an edge.
  task automatic bus(input logic [7:0] a, input logic we,
      input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task automatic poke(input logic [11:0] a, input logic [7:0] v);
    bus(`BIE_REG_MADDR, 1'b1, {20'h0, a});
    bus(`BIE_REG_MDATA, 1'b1, {24'h0, v});
  endtask

  task automatic peek(input logic [11:0] a, input logic [7:0] v);
    bus(`BIE_REG_MADDR, 1'b1, {20'h0, a});
    rd_chk(`BIE_REG_MDATA, {24'h0, v});
  endtask

  // No completion flag exists, so each program gets ample time to loop.
  task automatic run(input logic [20:0] pc, input logic [31:0] ctl);
    bus(`BIE_REG_PC, 1'b1, {11'h0, pc});
    bus(`BIE_REG_CTRL, 1'b1, ctl);
    repeat (120) @(posedge clk);
    bus(`BIE_REG_CTRL, 1'b1, 32'h0);
  endtask

  // Cuts a hang short well past the expected run length.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      u_mem.mem[i] = (i < 34) ? prog[i] : 16'h0;
    end
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // Registers come out of reset cleared; 0x20 is unmapped.
    for (int a = 0; a <= 32; a += 4) begin
      if (a != 28) rd_chk(8'(a), 32'h0);
    end
    bus(`BIE_REG_BANK, 1'b1, 32'h2);
    rd_chk(`BIE_REG_BANK, 32'h2);
    poke(12'h234, 8'hff);
    run(21'h0, 32'h1);
    peek(12'h234, 8'h00);
    rd_chk(`BIE_REG_STATUS, 32'h07);
    poke(12'h235, 8'h7f);
    run(21'h8, 32'h1);
    rd_chk(`BIE_REG_WREG, 32'h80);
    rd_chk(`BIE_REG_STATUS, 32'h1a);
    peek(12'h235, 8'h7f);
    poke(12'h005, 8'h00);
    poke(12'h238, 8'h05);
    poke(12'h236, 8'hff);
    poke(12'h237, 8'h00);
    run(21'h10, 32'h1);
    peek(12'h005, 8'h01);
    peek(12'h238, 8'h06);
    peek(12'h236, 8'h00);
    peek(12'h237, 8'h00);
    rd_chk(`BIE_REG_STATUS, 32'h0);
    poke(12'h23a, 8'h05);
    poke(12'h23b, 8'h00);
    poke(12'h23c, 8'hff);
    poke(12'h23d, 8'h00);
    run(21'h20, 32'h1);
    peek(12'h23a, 8'h04);
    peek(12'h23b, 8'h00);
    peek(12'h23c, 8'h00);
    peek(12'h23d, 8'h01);
    bus(`BIE_REG_INDEX, 1'b1, 32'h300);
    poke(12'h310, 8'h10);
    poke(12'h35f, 8'h20);
    poke(12'hf60, 8'h30);
    poke(12'h23e, 8'h00);
    run(21'h30, 32'h3);
    peek(12'h310, 8'h11);
    peek(12'h35f, 8'h21);
    peek(12'hf60, 8'h31);
    peek(12'h23e, 8'h00);
    bus(`BIE_REG_PC, 1'b0, 32'h0);
    check({rd[31:3], 3'h0}, 32'h100040);
    tally_and_finish();
  end
endmodule
